/* File: rtl/power_mode_control_apd.sv */
// Power mode control: two mode registers over AXI4-Lite, auto power-down, memory power gating.
// Assumes all pins synchronous to aclk; the host drives strobe and chip select.
//
// Operation
// - Register a bit 1 selects strobe power-down level
// - Register a bit 2 enables auto power-down
// - Register a bit 3 enables memory current saver
// - Register a bit 4 turns array fast mode off
// - Register a bit 6 gates macrocell clock
// - Register a bit 7 gates timer clock
// - Register b bit 0 selects counter clock
// - Register b bit 1 enables sleep
// - Counter idles unless enabled and strobe frozen at level bit; 15
// - Current saver reads zero after reset
// - Saver off, selected chip: memory always powered
// - Chip select high: memory in standby
// - Saver on: unselected memory in standby
// - Saver on, 8-bit bus: half array powered
// - Array resets fast; off after 100 ns static
// - Register a bit 5 gates array clock
// - Sleep needs enables, level bit, overflow
// - Strobe pulsing leaves power-down at once
// - Chip select high enters power-down at once
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module power_mode_control_apd
  import pm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic address_strobe,
  input wire logic chip_select_n,
  input wire logic device_clock_input,
  input wire logic port_e_pin7,
  input wire logic array_input_activity,
  input wire logic memory_selected,
  input wire logic memory_access,
  input wire logic byte_bus_mode,
  input wire logic odd_half_access,
  output logic power_down,
  output logic sleep,
  output logic memory_powered,
  output logic [1:0] memory_half_powered,
  output logic array_zero_power,
  output logic array_fast,
  output logic array_clock_enable,
  output logic macrocell_clock_enable,
  output logic timer_clock_enable,
  output logic device_clock_buffer_off
);
  logic [7:0] power_mode_reg_a;
  logic [7:0] power_mode_reg_b;
  logic [7:0] next_reg_a;
  logic [7:0] next_reg_b;
  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic [3:0] aw_addr;
  logic [3:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic do_write;
  logic overflow;
  logic counter_tick;
  logic auto_powerdown_enable;
  logic strobe_level;
  logic next_power_down;
  logic next_sleep;
  logic next_memory_powered;
  logic [1:0] next_half;
  logic next_array_zero;
  logic [7:0] status_byte;
  logic zero_power_raw;

  assign auto_powerdown_enable = power_mode_reg_a[bit_auto_powerdown_enable];
  assign strobe_level = power_mode_reg_a[bit_strobe_level];

  // Counter clock source: device clock or the alternate port pin, used as a tick.
  assign counter_tick = power_mode_reg_b[bit_counter_clk_sel] ?
                        device_clock_input : port_e_pin7;

  apd_counter counter_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(auto_powerdown_enable),
    .level(strobe_level),
    .strobe(address_strobe),
    .tick(counter_tick),
    .overflow(overflow)
  );

  idle_timer idle_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .fast_off(power_mode_reg_a[bit_fast_off]),
    .activity(array_input_activity),
    .zero_power(zero_power_raw)
  );

  // Write channel capture, register update and write response.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_reg_a = power_mode_reg_a;
    next_reg_b = power_mode_reg_b;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_held && w_held;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = resp_okay;
      if (aw_addr == reg_a_offset) begin
        if (w_strb[0]) begin
          next_reg_a = w_data[7:0];
        end
      end else if (aw_addr == reg_b_offset) begin
        if (w_strb[0]) begin
          next_reg_b = w_data[7:0];
        end
      end else if (aw_addr == status_offset) begin
        next_bresp = resp_okay;
      end else begin
        next_bresp = resp_slverr;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Read channel: registers in the low byte, status byte shows live power state.
  assign status_byte = {3'h0, array_zero_power, memory_powered, overflow, sleep, power_down};
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = resp_okay;
      if (s_axi_araddr == reg_a_offset) begin
        next_rdata = {24'h00_0000, power_mode_reg_a};
      end else if (s_axi_araddr == reg_b_offset) begin
        next_rdata = {24'h00_0000, power_mode_reg_b};
      end else if (s_axi_araddr == status_offset) begin
        next_rdata = {24'h00_0000, status_byte};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = resp_slverr;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Power state: chip select, auto power-down and sleep, memory gating.
  always_comb begin
    next_power_down = chip_select_n || overflow;
    next_sleep = power_mode_reg_b[bit_sleep_enable] && auto_powerdown_enable &&
                 strobe_level && overflow;
    next_array_zero = zero_power_raw;
    if (chip_select_n) begin
      next_memory_powered = 1'b0;
    end else if (!power_mode_reg_a[bit_saver]) begin
      next_memory_powered = 1'b1;
    end else begin
      next_memory_powered = memory_selected && memory_access;
    end
    if (next_memory_powered && power_mode_reg_a[bit_saver] && byte_bus_mode) begin
      next_half = odd_half_access ? 2'b10 : 2'b01;
    end else if (next_memory_powered) begin
      next_half = 2'b11;
    end else begin
      next_half = 2'b00;
    end
  end

  // Registers everything that software and the power logic hold.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_mode_reg_a <= reg_a_reset;
      power_mode_reg_b <= reg_b_reset;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      power_down <= 1'b0;
      sleep <= 1'b0;
      memory_powered <= 1'b0;
      memory_half_powered <= 2'b00;
      array_zero_power <= 1'b0;
    end else begin
      power_mode_reg_a <= next_reg_a;
      power_mode_reg_b <= next_reg_b;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      power_down <= next_power_down;
      sleep <= next_sleep;
      memory_powered <= next_memory_powered;
      memory_half_powered <= next_half;
      array_zero_power <= next_array_zero;
    end
  end

  // Clock gating levels straight from the mode register; the buffer-off level also needs overflow.
  assign array_fast = !power_mode_reg_a[bit_fast_off];
  assign array_clock_enable = !power_mode_reg_a[bit_array_clk_off];
  assign macrocell_clock_enable = !power_mode_reg_a[bit_macro_clk_off];
  assign timer_clock_enable = !power_mode_reg_a[bit_timer_clk_off];
  assign device_clock_buffer_off = (&power_mode_reg_a[7:5]) && overflow;

  // Chip select high powers down one cycle later.
  a_cs_powerdown: assert property (@(posedge aclk) disable iff (!aresetn)
    chip_select_n |=> power_down && !memory_powered) else $error("no power-down");
  // Sleep only with all enables set.
  a_sleep_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep |-> $past(power_mode_reg_b[1] && power_mode_reg_a[2] && power_mode_reg_a[1]))
    else $error("sleep without enables");
  // Saver off and selected keeps memory on.
  a_mem_on: assert property (@(posedge aclk) disable iff (!aresetn)
    !chip_select_n && !power_mode_reg_a[3] |=> memory_powered)
    else $error("memory off with saver off");
  // Saver on and unselected memory stands by.
  a_mem_saver: assert property (@(posedge aclk) disable iff (!aresetn)
    power_mode_reg_a[3] && !memory_selected |=> !memory_powered)
    else $error("memory on while unselected");
  // Byte mode with saver powers one half.
  a_half_only: assert property (@(posedge aclk) disable iff (!aresetn)
    memory_powered && $past(power_mode_reg_a[3] && byte_bus_mode) |-> memory_half_powered != 2'b11)
    else $error("both halves on");
  // Strobe movement leaves power-down next cycle with chip selected.
  a_strobe_wakes: assert property (@(posedge aclk) disable iff (!aresetn)
    address_strobe != $past(address_strobe) && !chip_select_n |=> !power_down && !sleep)
    else $error("no wake on strobe");
  // Mode bits gate the clocks.
  a_timer_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    power_mode_reg_a[7] |-> !timer_clock_enable && array_clock_enable == !power_mode_reg_a[5])
    else $error("clock gate wrong");
endmodule // power_mode_control_apd
`default_nettype wire

/* File: rtl/pm_pkg.sv */
// Package for the power mode control block: register map, bit positions, reset values, timing.
// Assumes a 125 MHz single clock and a 32-bit AXI4-Lite register bus.
package pm_pkg;
  localparam logic [3:0] reg_a_offset = 4'h0;
  localparam logic [3:0] reg_b_offset = 4'h4;
  localparam logic [3:0] status_offset = 4'h8;
  localparam logic [7:0] reg_a_reset = 8'h00;
  localparam logic [7:0] reg_b_reset = 8'h00;
  localparam int bit_a_reserved = 0;
  localparam int bit_strobe_level = 1;
  localparam int bit_auto_powerdown_enable = 2;
  localparam int bit_saver = 3;
  localparam int bit_fast_off = 4;
  localparam int bit_array_clk_off = 5;
  localparam int bit_macro_clk_off = 6;
  localparam int bit_timer_clk_off = 7;
  localparam int bit_counter_clk_sel = 0;
  localparam int bit_sleep_enable = 1;
  localparam logic [3:0] apd_overflow_count = 4'hF;
  localparam int clock_mhz = 125;
  localparam int idle_time_ns = 100;
  localparam int idle_cycles_raw = (idle_time_ns * clock_mhz + 999) / 1000;
  localparam logic [4:0] idle_cycles = 5'(idle_cycles_raw);
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
endpackage

/* File: rtl/apd_counter.sv */
// Automatic power-down counter: counts enabled clock ticks while the strobe is frozen at the level input.
// Assumes the strobe and the tick are synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module apd_counter
  import pm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic level,
  input wire logic strobe,
  input wire logic tick,
  output logic overflow
);
  logic strobe_prev;
  logic [3:0] count;
  logic [3:0] next_count;
  logic next_strobe_prev;
  logic edge_seen;

  // Next count: idle when disabled, strobe moves or strobe differs from level, else count toward overflow.
  always_comb begin
    edge_seen = strobe != strobe_prev;
    next_strobe_prev = strobe;
    next_count = count;
    if (!enable || edge_seen || strobe != level) begin
      next_count = 4'h0;
    end else if (tick && count != apd_overflow_count) begin
      next_count = count + 4'h1;
    end
  end

  // Registers the counter state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 4'h0;
      strobe_prev <= 1'b0;
    end else begin
      count <= next_count;
      strobe_prev <= next_strobe_prev;
    end
  end

  assign overflow = enable && !edge_seen && count == apd_overflow_count;

  // Counter never advances while disabled.
  a_idle_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |=> count == 4'h0) else $error("counter moved while disabled");
  // A strobe transition clears the count.
  a_edge_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    strobe != $past(strobe) |=> count == 4'h0) else $error("edge did not clear");
endmodule // apd_counter
`default_nettype wire

/* File: rtl/idle_timer.sv */
// Static-input timer for the logic array: flags zero power after inputs stay static.
// Assumes the activity flag is synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module idle_timer
  import pm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fast_off,
  input wire logic activity,
  output logic zero_power
);
  logic [4:0] count;
  logic [4:0] next_count;

  // Counts static cycles while fast mode is off; activity restarts it.
  always_comb begin
    next_count = count;
    if (!fast_off || activity) begin
      next_count = 5'h0;
    end else if (count != idle_cycles) begin
      next_count = count + 5'h1;
    end
  end

  // Registers the static-cycle count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 5'h0;
    end else begin
      count <= next_count;
    end
  end

  assign zero_power = fast_off && !activity && count == idle_cycles;

  // Fast mode or input activity restarts the static count, so the array stays powered.
  a_fast_powered: assert property (@(posedge aclk) disable iff (!aresetn)
    !fast_off || activity |=> count == 5'h0 && !zero_power) else $error("array off in fast mode");
endmodule // idle_timer
`default_nettype wire

/* File: testbench/host_mcu_model.sv */
// Host controller model: drives the address strobe and the chip select of a multiplexed bus.
// Assumes the same clock as the power mode block; the bench sets the host's activity.
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pulse_en,
  input wire logic frozen_level,
  input wire logic deselect,
  output logic address_strobe,
  output logic chip_select_n
);
  // The strobe toggles each cycle while bus cycles run, else it freezes at the chosen level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      address_strobe <= 1'h0;
      chip_select_n <= 1'h1;
    end else begin
      address_strobe <= pulse_en ? ~address_strobe : frozen_level;
      chip_select_n <= deselect;
    end
  end
endmodule // host_mcu_model
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the power mode block: register bus, auto power-down, memory gating.
// Assumes the host model drives strobe and chip select; all else is driven here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pm_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
  logic awready, wready, arready, dev_clk, pe7, activity, mem_sel, mem_acc, byte_mode;
  logic odd_half, pulse_en, frz_lvl, desel, strobe, cs_n, pd, slp, mem_pwr, zero_pwr;
  logic fast, aclk_en, mclk_en, tclk_en, buf_off;
  logic [1:0] bresp, rresp, half_pwr;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, v;
  logic [33:0] e;
  logic [33:0] exp_q[$];
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  power_mode_control_apd power_mode_control_apd_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .address_strobe(strobe), .chip_select_n(cs_n), .device_clock_input(dev_clk),
    .port_e_pin7(pe7), .array_input_activity(activity), .memory_selected(mem_sel),
    .memory_access(mem_acc), .byte_bus_mode(byte_mode), .odd_half_access(odd_half),
    .power_down(pd), .sleep(slp), .memory_powered(mem_pwr), .memory_half_powered(half_pwr),
    .array_zero_power(zero_pwr), .array_fast(fast), .array_clock_enable(aclk_en),
    .macrocell_clock_enable(mclk_en), .timer_clock_enable(tclk_en),
    .device_clock_buffer_off(buf_off));

  host_mcu_model host_mcu_model_inst (
    .aclk(aclk), .aresetn(aresetn), .pulse_en(pulse_en), .frozen_level(frz_lvl),
    .deselect(desel), .address_strobe(strobe), .chip_select_n(cs_n));

  // Free-running 125 MHz clock.
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end

  // Counts one comparison and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
    checks_done++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, want);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic wrap_up;
    $display("Errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Write: address and data offered together, each released when taken, then the response.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
    check(32'(bresp), 32'(er), "write response");
  endtask

  // Read: the expected word is noted in the queue; the monitor compares it.
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    exp_q.push_back({er, ed});
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rready <= 1'h0;
  endtask

  // Takes the oldest note whenever read data is handed over.
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("unexpected at %0t: read data with no note", $time);
      end else begin
        e = exp_q.pop_front();
        check(32'({rresp, rdata}), 32'(e), "read word");
        check(32'(rresp), 32'(e[33:32]), "read response");
      end
    end
  end

  // Cuts a hang short.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("unexpected at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  // Waits a number of cycles, then compares the power-down and sleep levels.
  task automatic pd_after(input int n, input logic epd, input logic esl);
    repeat (n) @(posedge aclk);
    check(32'(pd), 32'(epd), "power down");
    check(32'(slp), 32'(esl), "sleep");
  endtask

  // Restarts host bus activity, programs both registers, then freezes the strobe.
  task automatic arm(input logic [31:0] ra, input logic [31:0] rb, input logic lvl);
    pulse_en <= 1'h1;
    wr(reg_b_offset, rb, resp_okay);
    wr(reg_a_offset, ra, resp_okay);
    pd_after(2, 1'h0, 1'h0);
    frz_lvl <= lvl;
    pulse_en <= 1'h0;
  endtask

  // Main sequence.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, dev_clk, pe7, activity} = '0;
    {mem_sel, mem_acc, byte_mode, odd_half, frz_lvl, desel} = '0;
    pulse_en = 1'h1;
    awaddr = 4'h0;
    araddr = 4'h0;
    wstrb = 4'h0;
    wdata = 32'h0000_0000;
    void'($urandom(32'h134b1a65));
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd(reg_a_offset, 32'h0000_0000, resp_okay);
    rd(reg_b_offset, 32'h0000_0000, resp_okay);
    check(32'({fast, aclk_en, mclk_en, tclk_en}), 32'h0000_000F, "clock enables");
    v = $urandom;
    wr(reg_a_offset, v, resp_okay);
    rd(reg_a_offset, {24'h00_0000, v[7:0]}, resp_okay);
    rd(4'hC, 32'h0000_0000, resp_slverr);
    wr(4'hC, v, resp_slverr);
    wr(status_offset, v, resp_okay);
    for (int i = 4; i < 8; i++) begin
      wr(reg_a_offset, 32'h0000_0001 << i, resp_okay);
      pd_after(1, 1'h0, 1'h0);
      check(32'({tclk_en, mclk_en, aclk_en, fast}), 32'(4'(~(4'h1 << (i - 4)))), "decode");
    end
    dev_clk <= 1'h1;
    arm(32'h0000_0007, 32'h0000_0001, 1'h1);
    pd_after(12, 1'h0, 1'h0);
    pd_after(8, 1'h1, 1'h0);
    pulse_en <= 1'h1;
    pd_after(3, 1'h0, 1'h0);
    frz_lvl <= 1'h1;
    pulse_en <= 1'h0;
    repeat (10) @(posedge aclk);
    pulse_en <= 1'h1;
    repeat (2) @(posedge aclk);
    pulse_en <= 1'h0;
    pd_after(10, 1'h0, 1'h0);
    arm(32'h0000_0007, 32'h0000_0001, 1'h0);
    pd_after(25, 1'h0, 1'h0);
    arm(32'h0000_0003, 32'h0000_0001, 1'h1);
    pd_after(25, 1'h0, 1'h0);
    arm(32'h0000_0007, 32'h0000_0000, 1'h1);
    pd_after(25, 1'h0, 1'h0);
    pe7 <= 1'h1;
    pd_after(20, 1'h1, 1'h0);
    arm(32'h0000_00E7, 32'h0000_0003, 1'h1);
    check(32'(buf_off), 32'h0000_0000, "buffer off");
    pd_after(20, 1'h1, 1'h1);
    check(32'(buf_off), 32'h0000_0001, "buffer off");
    rd(status_offset, 32'h0000_000F, resp_okay);
    arm(32'h0000_0005, 32'h0000_0003, 1'h0);
    pd_after(20, 1'h1, 1'h0);
    pulse_en <= 1'h1;
    desel <= 1'h1;
    pd_after(3, 1'h1, 1'h0);
    check(32'(mem_pwr), 32'h0000_0000, "memory power");
    desel <= 1'h0;
    wr(reg_a_offset, 32'h0000_0001, resp_okay);
    pd_after(2, 1'h0, 1'h0);
    check(32'(mem_pwr), 32'h0000_0001, "memory power");
    wr(reg_a_offset, 32'h0000_0009, resp_okay);
    pd_after(2, 1'h0, 1'h0);
    check(32'(mem_pwr), 32'h0000_0000, "memory power");
    {mem_sel, mem_acc, byte_mode, odd_half} <= 4'hF;
    pd_after(2, 1'h0, 1'h0);
    check(32'({mem_pwr, half_pwr}), 32'h0000_0006, "odd half");
    odd_half <= 1'h0;
    pd_after(2, 1'h0, 1'h0);
    check(32'({mem_pwr, half_pwr}), 32'h0000_0005, "even half");
    wr(reg_a_offset, 32'h0000_0010, resp_okay);
    pd_after(11, 1'h0, 1'h0);
    check(32'(zero_pwr), 32'h0000_0000, "zero power early");
    pd_after(3, 1'h0, 1'h0);
    check(32'(zero_pwr), 32'h0000_0001, "zero power");
    activity <= 1'h1;
    pd_after(3, 1'h0, 1'h0);
    check(32'(zero_pwr), 32'h0000_0000, "zero power wake");
    activity <= 1'h0;
    wr(reg_a_offset, 32'h0000_0000, resp_okay);
    pd_after(25, 1'h0, 1'h0);
    check(32'(zero_pwr), 32'h0000_0000, "fast mode");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
